// ---- include/bpsc_pkg.sv ----
// Package with the constants and carrier types of the bridge power state controller.
package bpsc_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned READY_FILTER_MS = 25;
  localparam int unsigned RESET_DELAY_MS = 25;
  localparam int unsigned READY_FILTER_CYCLES = (CLK_HZ / 1000) * READY_FILTER_MS;
  localparam int unsigned RESET_DELAY_CYCLES = (CLK_HZ / 1000) * RESET_DELAY_MS;
  localparam int unsigned TIMER_WIDTH = 21;
  localparam int unsigned RESET_PULSE_CYCLES = 50;

  localparam int unsigned DATA_WIDTH = 16;
  localparam int unsigned CS_WIDTH = 2;
  localparam int unsigned ADDR_WIDTH = 3;

  localparam logic [1:0] SYNC_RESET = 2'h0;
  localparam logic DESC_SET_FIRST = 1'h0;
  localparam logic DESC_SET_SECOND = 1'h1;

  typedef enum logic [1:0] {
    BPSC_LINE_SUSPEND,
    BPSC_LINE_OPERATIONAL,
    BPSC_LINE_FLOAT
  } bpsc_line_t;

  // Drive levels of the storage bus control pins, whether idle, active or suspended.
  typedef struct packed {
    logic [CS_WIDTH-1:0] chipSelectN;
    logic [ADDR_WIDTH-1:0] regAddress;
    logic readStrobeN;
    logic writeStrobeN;
    logic dmaAckN;
    logic storageBusResetN;
    logic busPulldownEnable;
    logic busPullupEnable;
  } bpsc_ctrl_pins_t;

  // Power qualifying inputs after synchronisation.
  typedef struct packed {
    logic busDrawSelect;
    logic drivePowerOk;
    logic hostSupplyPresent;
    logic attachedDriveReady;
    logic storagePortEnable;
  } bpsc_power_in_t;

  localparam bpsc_ctrl_pins_t PINS_LOW = '0;
  localparam bpsc_ctrl_pins_t PINS_IDLE = '{
    chipSelectN: '1, regAddress: '1, readStrobeN: 1'h1, writeStrobeN: 1'h1,
    dmaAckN: 1'h1, storageBusResetN: 1'h1, busPulldownEnable: 1'h0,
    busPullupEnable: 1'h1};

endpackage

// ---- src/bpsc_ready_filter.sv ----
// Drive ready filter: accepts a rise after a stable period, drops on a fall at once.
`timescale 1ns/1ps
`default_nettype none
module bpsc_ready_filter #(
  parameter int unsigned FILTER_CYCLES = bpsc_pkg::READY_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Raw and synchronised ready input
  input wire logic readyRaw,
  input wire logic readySync,
  // Filtered result
  output logic readyFiltered,
  output logic readyRise
);

  logic [bpsc_pkg::TIMER_WIDTH-1:0] count;
  logic [bpsc_pkg::TIMER_WIDTH-1:0] next_count;
  logic readyState;
  logic countDone;
  logic dropNow;

  assign countDone = (count >= bpsc_pkg::TIMER_WIDTH'(FILTER_CYCLES - 1));
  // The raw pin is looked at only to clear; no decision is taken on it otherwise.
  assign dropNow = ~readyRaw | ~readySync; // R12 R24
  assign next_count = (readySync && !countDone) ? count + 1'b1 : count;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= '0;
      readyState <= 1'b0;
      readyRise <= 1'b0;
    end
    else if (dropNow)
    begin
      count <= '0;
      readyState <= 1'b0; // R12
      readyRise <= 1'b0;
    end
    else
    begin
      count <= next_count;
      readyState <= readyState | countDone; // R12
      readyRise <= countDone & ~readyState;
    end
  end

  assign readyFiltered = readyState & readyRaw; // R12

endmodule
`default_nettype wire

// ---- src/bpsc_power_control.sv ----
// Top of the bridge power state controller: power qualifying, low power and line states.
// Operation
// (R1) Status reply reports self or bus powered from bus-draw select level.
// (R2) Internal reset when bus-draw select high under a self-powered configuration.
// (R3) Internal reset when bus-draw select changes while configuration value is zero.
// (R4) First descriptor set when bus-draw select asserted, otherwise second set.
// (R5) Configuration enables drive-power-ok and chooses its active polarity.
// (R6) Enabled inactive drive-power-ok after configuration load enters low power.
// (R7) Low power from drive power loss ends when drive-power-ok becomes active.
// (R8) D+ pull-up driven only while host supply is present.
// (R9) Host supply absent after configuration load enters low power.
// (R10) Host supply returning resumes normal operation.
// (R11) Drive ready rise: wait 25 ms, then pulse storage bus reset.
// (R12) Ready accepted after 25 ms stable high, cleared at once on falling.
// (R13) Ready low with port enabled: machines idle, bus outputs driven low.
// (R14) Low power flag active in any low power state.
// (R15) Power grant asserted under bus-powered configuration with bus-draw select active.
// (R16) USB suspend drops power grant and enters low power.
// (R17) USB resume restores operation and power grant as configuration requires.
// (R18) Suspended line state drives all storage bus pins low.
// (R19) Operational state: pulldown 0, pullup 1, idle controls high.
// (R20) Port disabled floats every storage bus signal, pull enables included.
// (R21) Chip reset low with port enabled selects suspended line state.
// (R22) Operational only with reset, enable, ready high and drive power valid.
// (R23) Port disabled suspends storage machines while USB continues.
// (R24) Asynchronous power inputs synchronised before use in decisions; port enable and the ready drop use the raw pins.
`timescale 1ns/1ps
`default_nettype none
module bpsc_power_control #(
  parameter int unsigned READY_FILTER_CYCLES = bpsc_pkg::READY_FILTER_CYCLES,
  parameter int unsigned RESET_DELAY_CYCLES = bpsc_pkg::RESET_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Power qualifying pins
  input wire logic busDrawSelect,
  input wire logic drivePowerOk,
  input wire logic hostSupplyPresent,
  input wire logic attachedDriveReady,
  input wire logic storagePortEnable,
  input wire logic chipReset_n,
  // Configuration and USB state from the protocol engine
  input wire logic configLoaded,
  input wire logic drivePowerEnable,
  input wire logic drivePowerActiveHigh,
  input wire logic [7:0] usbConfigValue,
  input wire logic configSelfPowered,
  input wire logic usbSuspend,
  // Storage bus data driven by the command engine while operational
  input wire logic [bpsc_pkg::DATA_WIDTH-1:0] busDataOut,
  input wire logic busDataDrive,
  input wire bpsc_pkg::bpsc_ctrl_pins_t busActivePins,
  input wire logic busActive,
  // Power and USB outputs
  output logic statusSelfPowered,
  output logic descriptorSet,
  output logic internalReset,
  output logic dplusPullup,
  output logic low_power_flag_n,
  output logic power_grant_n,
  output logic storageMachinesRun,
  // Storage bus pins
  output logic [bpsc_pkg::DATA_WIDTH-1:0] busData,
  output logic busDataOe,
  output bpsc_pkg::bpsc_ctrl_pins_t busPins,
  output logic busPinsOe,
  output bpsc_pkg::bpsc_line_t lineState
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers.

  bpsc_pkg::bpsc_power_in_t syncA;
  bpsc_pkg::bpsc_power_in_t syncB;
  bpsc_pkg::bpsc_power_in_t rawIn;
  logic resetSyncA;
  logic resetSyncB;

  assign rawIn = '{busDrawSelect: busDrawSelect, drivePowerOk: drivePowerOk,
    hostSupplyPresent: hostSupplyPresent, attachedDriveReady: attachedDriveReady,
    storagePortEnable: storagePortEnable};

  // Two flops per pin, so a pin that moves near the edge settles before the synchronised decisions see it; port enable and the ready drop read the raw pins.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncA <= '0;
      syncB <= '0;
      resetSyncA <= 1'b0;
      resetSyncB <= 1'b0;
    end
    else
    begin
      syncA <= rawIn; // R24
      syncB <= syncA; // R24
      resetSyncA <= chipReset_n;
      resetSyncB <= resetSyncA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power qualification.

  logic drivePowerGood;
  logic lowPower;
  logic drawPrev;
  logic drawChanged;
  logic next_internalReset;
  logic configActive;
  logic grantNow;

  // Disabled means the input never blocks; polarity is chosen by configuration.
  assign drivePowerGood = !drivePowerEnable ||
    (syncB.drivePowerOk == drivePowerActiveHigh); // R5
  // Low power is a level recomputed each cycle, so each cause clears itself on return.
  assign lowPower = (configLoaded && !drivePowerGood) || // R6 R7
    (configLoaded && !syncB.hostSupplyPresent) || // R9 R10
    usbSuspend; // R16 R17
  assign drawChanged = syncB.busDrawSelect ^ drawPrev;
  // A zero configuration value means the host has not configured the device yet.
  assign configActive = (usbConfigValue != 8'h00);
  assign next_internalReset =
    (syncB.busDrawSelect && configSelfPowered && configActive) || // R2
    (drawChanged && !configActive); // R3
  // The grant drops on suspend and returns by itself once the suspend level falls.
  assign grantNow = syncB.busDrawSelect && !configSelfPowered && configActive &&
    !usbSuspend; // R15 R16 R17

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drawPrev <= 1'b0;
      internalReset <= 1'b0;
      statusSelfPowered <= 1'b1;
      descriptorSet <= bpsc_pkg::DESC_SET_SECOND;
      dplusPullup <= 1'b0;
      low_power_flag_n <= 1'b1;
      power_grant_n <= 1'b1;
    end
    else
    begin
      drawPrev <= syncB.busDrawSelect;
      internalReset <= next_internalReset; // R2 R3
      statusSelfPowered <= ~syncB.busDrawSelect; // R1
      descriptorSet <= syncB.busDrawSelect ? bpsc_pkg::DESC_SET_FIRST :
        bpsc_pkg::DESC_SET_SECOND; // R4
      dplusPullup <= syncB.hostSupplyPresent & ~lowPower; // R8
      low_power_flag_n <= ~lowPower; // R14
      power_grant_n <= ~grantNow; // R15 R16 R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive ready filter and delayed storage bus reset.

  logic readyFiltered;
  logic readyRise;
  logic [bpsc_pkg::TIMER_WIDTH-1:0] delayCount;
  logic delayRun;
  logic [7:0] pulseCount;
  logic pulseOn;
  logic delayDone;
  logic pulseDone;
  logic resetWaiting;
  logic [bpsc_pkg::TIMER_WIDTH-1:0] next_delayCount;
  logic [7:0] next_pulseCount;

  // The filter looks at the raw pin only to drop ready; acceptance uses the synchronised copy.
  bpsc_ready_filter #(
    .FILTER_CYCLES(READY_FILTER_CYCLES)
  ) u_ready_filter (
    .clk(clk),
    .reset_n(reset_n),
    .readyRaw(attachedDriveReady),
    .readySync(syncB.attachedDriveReady),
    .readyFiltered(readyFiltered),
    .readyRise(readyRise)
  );

  assign delayDone = delayRun &&
    (delayCount >= bpsc_pkg::TIMER_WIDTH'(RESET_DELAY_CYCLES - 1));
  assign pulseDone = (pulseCount >= 8'(bpsc_pkg::RESET_PULSE_CYCLES - 1));
  assign next_delayCount = delayRun ? delayCount + 1'b1 : delayCount;
  assign next_pulseCount = pulseOn ? pulseCount + 1'b1 : pulseCount;
  // The cycle of the accepted rise counts as waiting too, else the machines would run once.
  assign resetWaiting = readyRise || delayRun; // R11

  // A ready drop cancels the wait at once, so a bouncing drive never gets a stale reset.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      delayCount <= '0;
      delayRun <= 1'b0;
    end
    else if (!readyFiltered)
    begin
      delayCount <= '0;
      delayRun <= 1'b0;
    end
    else if (readyRise)
    begin
      delayCount <= '0;
      delayRun <= 1'b1; // R11
    end
    else if (delayDone)
    begin
      delayRun <= 1'b0;
    end
    else
    begin
      delayCount <= next_delayCount;
    end
  end

  // Storage bus reset pulse of fixed width, started when the wait runs out.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pulseCount <= '0;
      pulseOn <= 1'b0;
    end
    else if (!readyFiltered)
    begin
      pulseCount <= '0;
      pulseOn <= 1'b0;
    end
    else if (delayDone)
    begin
      pulseCount <= '0;
      pulseOn <= 1'b1; // R11
    end
    else
    begin
      pulseCount <= next_pulseCount;
      pulseOn <= pulseOn && !pulseDone; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line state selection and pin drive.

  bpsc_pkg::bpsc_line_t next_lineState;
  bpsc_pkg::bpsc_ctrl_pins_t opPins;
  bpsc_pkg::bpsc_ctrl_pins_t next_busPins;
  logic operational;
  logic nextOperational;

  // Selecting a line state and testing for it are kept in one place.
  function automatic logic line_is_operational(input bpsc_pkg::bpsc_line_t line);
    return line == bpsc_pkg::BPSC_LINE_OPERATIONAL;
  endfunction

  // Port enable is not synchronised here so that floating follows it promptly.
  assign operational = resetSyncB && readyFiltered && drivePowerGood; // R22
  assign next_lineState = !storagePortEnable ? bpsc_pkg::BPSC_LINE_FLOAT : // R20
    (!resetSyncB ? bpsc_pkg::BPSC_LINE_SUSPEND : // R21
    (operational ? bpsc_pkg::BPSC_LINE_OPERATIONAL :
    bpsc_pkg::BPSC_LINE_SUSPEND)); // R13 R22
  assign nextOperational = line_is_operational(next_lineState);

  always_comb
  begin
    opPins = busActive && !pulseOn && !resetWaiting ? busActivePins :
      bpsc_pkg::PINS_IDLE; // R19
    opPins.busPulldownEnable = 1'b0; // R19
    opPins.busPullupEnable = 1'b1; // R19
    opPins.storageBusResetN = ~pulseOn; // R11
  end

  // Every pin is driven from a flop, so the pads never see the select logic settle.
  assign next_busPins = nextOperational ? opPins : bpsc_pkg::PINS_LOW; // R18 R19

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lineState <= bpsc_pkg::BPSC_LINE_FLOAT;
      busPins <= bpsc_pkg::PINS_LOW;
      busPinsOe <= 1'b0;
      busData <= '0;
      busDataOe <= 1'b0;
      storageMachinesRun <= 1'b0;
    end
    else
    begin
      lineState <= next_lineState;
      busPins <= next_busPins; // R18 R19
      busPinsOe <= storagePortEnable; // R20
      busData <= nextOperational ? busDataOut : '0; // R18
      busDataOe <= storagePortEnable && (!nextOperational || busDataDrive); // R18 R20
      storageMachinesRun <= nextOperational && !resetWaiting; // R11 R13 R23
    end
  end

endmodule
`default_nettype wire

// ---- bench/bpsc_drive_model.sv ----
// Storage device model: raises ready a while after its power comes up.
`timescale 1ns/1ps
`default_nettype none
module bpsc_drive_model #(
  parameter int unsigned READY_LAG = 5
) (
  // Bench control
  input wire logic clk,
  input wire logic powerOn,
  input wire logic groundScheme,
  // Pins toward the controller
  output logic driveReady,
  output logic drivePowerOk
);
  int lag = 0;
  // A grounding cable pulls the line low when attached, so the level inverts.
  assign drivePowerOk = groundScheme ? !powerOn : powerOn;
  assign driveReady = lag >= READY_LAG;
  always @(posedge clk)
    lag <= powerOn ? lag + (lag < READY_LAG) : 0;
endmodule
`default_nettype wire

// ---- bench/bpsc_power_control_props.sv ----
// Checker of the power state controller port timing.
`timescale 1ns/1ps
`default_nettype none
module bpsc_power_control_props #(
  parameter int unsigned READY_FILTER_CYCLES = 20,
  parameter int unsigned RESET_DELAY_CYCLES = 20
) (
  // Clock, reset and inputs
  input wire logic clk,
  input wire logic reset_n,
  input wire logic busDrawSelect,
  input wire logic hostSupplyPresent,
  input wire logic attachedDriveReady,
  input wire logic storagePortEnable,
  input wire logic [7:0] usbConfigValue,
  input wire logic configSelfPowered,
  input wire logic usbSuspend,
  // Outputs
  input wire logic statusSelfPowered,
  input wire logic descriptorSet,
  input wire logic internalReset,
  input wire logic dplusPullup,
  input wire logic low_power_flag_n,
  input wire logic power_grant_n,
  input wire logic storageMachinesRun,
  input wire logic busDataOe,
  input wire bpsc_pkg::bpsc_ctrl_pins_t busPins,
  input wire logic busPinsOe,
  input wire bpsc_pkg::bpsc_line_t lineState
);
  int readyRun;
  wire logic selfBad = busDrawSelect && configSelfPowered && usbConfigValue != 8'h00;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      readyRun <= 0;
    else if (!attachedDriveReady)
      readyRun <= 0;
    else if (readyRun < 9999)
      readyRun <= readyRun + 1;
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  AST_SELECT: assert property ($stable(busDrawSelect) [*6] |->
    statusSelfPowered == descriptorSet && statusSelfPowered != busDrawSelect)
    else $error("select reply wrong");
  AST_SELF_RESET: assert property ($rose(selfBad) |-> ##[1:6] internalReset)
    else $error("no internal reset");
  AST_PULLUP: assert property (!hostSupplyPresent [*4] |-> !dplusPullup)
    else $error("pullup without host");
  AST_SUSPEND: assert property (usbSuspend [*5] |-> power_grant_n && !low_power_flag_n)
    else $error("suspend not honoured");
  AST_FLOAT: assert property (!storagePortEnable [*3] |-> !busPinsOe && !busDataOe
    && lineState == bpsc_pkg::BPSC_LINE_FLOAT) else $error("port not floated");
  AST_SUSP_PINS: assert property (lineState == bpsc_pkg::BPSC_LINE_SUSPEND |->
    busPins == bpsc_pkg::PINS_LOW && busDataOe) else $error("suspend pins wrong");
  AST_READY_FILTER: assert property ($rose(storageMachinesRun) |->
    readyRun >= READY_FILTER_CYCLES + RESET_DELAY_CYCLES) else $error("ready too early");
  AST_READY_DROP: assert property (!attachedDriveReady [*4] |-> !storageMachinesRun
    && lineState != bpsc_pkg::BPSC_LINE_OPERATIONAL) else $error("ready drop missed");
  AST_RESET_PULSE: assert property ($fell(busPins.storageBusResetN) &&
    lineState == bpsc_pkg::BPSC_LINE_OPERATIONAL |-> !busPins.storageBusResetN [*8])
    else $error("reset pulse short");
  cover property ($rose(storageMachinesRun));
  cover property ($fell(low_power_flag_n));
  cover property (lineState == bpsc_pkg::BPSC_LINE_FLOAT);
endmodule
bind bpsc_power_control bpsc_power_control_props #(
  .READY_FILTER_CYCLES(READY_FILTER_CYCLES),
  .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)
) props (.clk, .reset_n, .busDrawSelect, .hostSupplyPresent, .attachedDriveReady,
  .storagePortEnable, .usbConfigValue, .configSelfPowered, .usbSuspend, .statusSelfPowered,
  .descriptorSet, .internalReset, .dplusPullup, .low_power_flag_n, .power_grant_n,
  .storageMachinesRun, .busDataOe, .busPins, .busPinsOe, .lineState);
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench of the bridge power state controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned FILT = 20;
  localparam int unsigned DELAY = 20;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic busDrawSelect = 1'h0;
  logic hostSupplyPresent = 1'h1;
  logic storagePortEnable = 1'h1;
  logic chipReset_n = 1'h1;
  logic configLoaded = 1'h1;
  logic drivePowerEnable = 1'h0;
  logic drivePowerActiveHigh = 1'h1;
  logic configSelfPowered = 1'h0;
  logic usbSuspend = 1'h0;
  logic drivePowered = 1'h1;
  logic [7:0] usbConfigValue = 8'h00;
  logic [15:0] busDataOut = 16'h0000;
  logic busDataDrive = 1'h0;
  logic busActive = 1'h0;
  bpsc_pkg::bpsc_ctrl_pins_t busActivePins = bpsc_pkg::PINS_LOW;
  logic [31:0] seed = 32'hfab8_73de;
  wire logic ready;
  wire logic dpOk;
  logic statusSelfPowered, descriptorSet, internalReset, dplusPullup, low_power_flag_n;
  logic power_grant_n, storageMachinesRun, busDataOe, busPinsOe;
  logic [15:0] busData;
  bpsc_pkg::bpsc_ctrl_pins_t busPins;
  bpsc_pkg::bpsc_line_t lineState;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  bpsc_drive_model #(.READY_LAG(5)) drive (.clk, .powerOn(drivePowered),
    .groundScheme(!drivePowerActiveHigh), .driveReady(ready), .drivePowerOk(dpOk));
  bpsc_power_control #(.READY_FILTER_CYCLES(FILT), .RESET_DELAY_CYCLES(DELAY)) uut (
    .clk, .reset_n, .busDrawSelect, .drivePowerOk(dpOk), .hostSupplyPresent,
    .attachedDriveReady(ready), .storagePortEnable, .chipReset_n, .configLoaded,
    .drivePowerEnable, .drivePowerActiveHigh, .usbConfigValue, .configSelfPowered,
    .usbSuspend, .busDataOut, .busDataDrive, .busActivePins, .busActive, .statusSelfPowered,
    .descriptorSet, .internalReset, .dplusPullup, .low_power_flag_n, .power_grant_n,
    .storageMachinesRun, .busData, .busDataOe, .busPins, .busPinsOe, .lineState);
  always #10 clk = !clk;
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      summarize();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic saw_reset(input string what);
    logic seen;
    seen = 1'h0;
    repeat (8)
    begin
      step(1);
      seen = seen | internalReset;
    end
    chk(seen, 1'h1, what);
  endtask
  // Levels of the controller settle well inside the wait, so one model covers every mix.
  task automatic check_all();
    logic dpBad, lowPwr, grant, lineKnown;
    bpsc_pkg::bpsc_line_t line;
    bpsc_pkg::bpsc_ctrl_pins_t opPins;
    step(150);
    dpBad = drivePowerEnable && !drivePowered;
    lowPwr = usbSuspend || (configLoaded && (!hostSupplyPresent || dpBad));
    grant = busDrawSelect && !configSelfPowered && usbConfigValue != 8'h00 && !usbSuspend;
    lineKnown = !usbSuspend && !(configLoaded && !hostSupplyPresent);
    line = !storagePortEnable ? bpsc_pkg::BPSC_LINE_FLOAT
      : (!chipReset_n || dpBad || !ready) ? bpsc_pkg::BPSC_LINE_SUSPEND
      : bpsc_pkg::BPSC_LINE_OPERATIONAL;
    opPins = busActive ? busActivePins : bpsc_pkg::PINS_IDLE;
    opPins.busPulldownEnable = 1'h0;
    opPins.busPullupEnable = 1'h1;
    opPins.storageBusResetN = 1'h1;
    chk(statusSelfPowered, !busDrawSelect, "status");
    chk(descriptorSet, busDrawSelect ? bpsc_pkg::DESC_SET_FIRST : bpsc_pkg::DESC_SET_SECOND,
      "descriptor set");
    chk(low_power_flag_n, !lowPwr, "low power flag");
    chk(dplusPullup, hostSupplyPresent && !lowPwr, "pullup");
    chk(busPinsOe, storagePortEnable, "pins enable");
    if (!(configLoaded && (!hostSupplyPresent || dpBad)))
      chk(power_grant_n, !grant, "power grant");
    chk(busData, (line == bpsc_pkg::BPSC_LINE_OPERATIONAL) ? busDataOut : '0, "data");
    if (lineKnown)
      chk({lineState, busDataOe, storageMachinesRun}, {line, line ==
        bpsc_pkg::BPSC_LINE_SUSPEND || (line == bpsc_pkg::BPSC_LINE_OPERATIONAL && busDataDrive),
        line == bpsc_pkg::BPSC_LINE_OPERATIONAL}, "line");
    if (lineKnown && line != bpsc_pkg::BPSC_LINE_FLOAT)
      chk(busPins, line == bpsc_pkg::BPSC_LINE_SUSPEND ? bpsc_pkg::PINS_LOW
        : opPins, "bus pins");
  endtask
  task automatic check_reset();
    chk({statusSelfPowered, descriptorSet, low_power_flag_n, power_grant_n, busPinsOe,
      busDataOe, lineState}, 8'hf2, "reset values");
  endtask
  initial
  begin
    step(20);
    check_reset();
    reset_n = 1'h1;
    for (n = 0; n < 500 && lineState !== bpsc_pkg::BPSC_LINE_OPERATIONAL; n++)
      step(1);
    chk(n >= FILT, 1'h1, "filter wait");
    chk(storageMachinesRun, 1'h0, "run in delay");
    for (n = 0; n < 500 && busPins.storageBusResetN !== 1'h0; n++)
      step(1);
    chk(n + 2 >= DELAY, 1'h1, "reset delay");
    for (n = 0; n < 500 && busPins.storageBusResetN === 1'h0; n++)
      step(1);
    chk(n, bpsc_pkg::RESET_PULSE_CYCLES, "reset width");
    busDrawSelect = 1'h1;
    saw_reset("select change unconfigured");
    usbConfigValue = 8'h01;
    check_all();
    chk(internalReset, 1'h0, "no reset");
    configSelfPowered = 1'h1;
    saw_reset("select high self powered");
    repeat (24)
    begin
      seed = lfsr(seed);
      {busDrawSelect, configSelfPowered, usbSuspend, drivePowerEnable} = seed[3:0];
      {drivePowerActiveHigh, configLoaded} = seed[5:4];
      usbConfigValue = seed[15:8];
      {busDataDrive, busActive} = seed[7:6];
      busDataOut = seed[31:16];
      busActivePins = seed[26:16];
      hostSupplyPresent = seed[16] | seed[17];
      drivePowered = seed[18] | seed[19];
      chipReset_n = seed[20] | seed[21];
      storagePortEnable = seed[22] | seed[23];
      check_all();
    end
    reset_n = 1'h0;
    step(2);
    check_reset();
    reset_n = 1'h1;
    check_all();
    summarize();
  end
endmodule
`default_nettype wire
